// ==== ddc_cfg_pkg.sv ====
package ddc_cfg_pkg;
   // Register indices; the bus byte address is four times the index
   localparam logic [7:0] PATH_ROUTING_CONTROL_ADDR = 8'h24;
   localparam logic [7:0] DECIMATION_CONTROL_ADDR = 8'h25;
   localparam logic [7:0] MIXER_CONTROL_ADDR = 8'h26;
   localparam logic [7:0] PATH_MASK = 8'h3e;
   localparam logic [7:0] DECIM_MASK = 8'hf9;
   localparam logic [7:0] MIXER_MASK = 8'hff;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int AVG_BIT = 5;
   localparam int SEL_LSB = 3;
   localparam int INCLUDE_BIT = 2;
   localparam int DEC_EN_BIT = 1;
   localparam int ROUTE_EN_BIT = 7;
   localparam int FACTOR_LSB = 4;
   localparam int REAL_BIT = 3;
   localparam int PHASE_INV_BIT = 0;
   localparam int GAIN_A_LSB = 6;
   localparam int RELOAD_A_BIT = 5;
   localparam int QMIX_A_BIT = 4;
   localparam int GAIN_B_LSB = 2;
   localparam int RELOAD_B_BIT = 1;
   localparam int QMIX_B_BIT = 0;
   localparam logic [2:0] FACTOR_MAX = 3'h5;
   localparam logic [1:0] GAIN_UNUSED = 2'h3;
   typedef enum logic [1:0] {
      SEL_STRAIGHT = 2'b00,
      SEL_BOTH_A = 2'b01,
      SEL_BOTH_B = 2'b10,
      SEL_AVERAGE = 2'b11
   } input_select_e;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ddc_cfg_pkg

// ==== ddc_decimator.sv ====
`timescale 1ns/1ps
module ddc_decimator (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic [2:0] i_factor,
   output logic o_strobe
);
   logic [4:0] count;
   wire logic [4:0] last = (i_factor <= ddc_cfg_pkg::FACTOR_MAX) ? 5'((6'h1 << i_factor) - 6'h1) : 5'h00;
   wire logic wrap = (count >= last);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= '0;
         o_strobe <= 1'b0;
      end else begin
         count <= (!i_enable || wrap) ? 5'h00 : count + 5'h01;
         o_strobe <= !i_enable || wrap;
      end
   end
endmodule : ddc_decimator

// ==== ddc_path_config.sv ====
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module ddc_path_config #(
   parameter int SAMPLE_WIDTH = 16
) (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   // AXI4-Lite write address
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_AWADDR,
   // AXI4-Lite write data
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   // AXI4-Lite write response
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   // AXI4-Lite read address
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [31:0] I_ARADDR,
   // AXI4-Lite read data
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   // Converter samples
   input wire logic [SAMPLE_WIDTH-1:0] I_SAMPLE_A,
   input wire logic [SAMPLE_WIDTH-1:0] I_SAMPLE_B,
   // Downconverter feeds
   output logic [SAMPLE_WIDTH-1:0] O_DDC_A,
   output logic [SAMPLE_WIDTH-1:0] O_DDC_B,
   output logic O_DIGITAL_INCLUDE,
   output logic O_DECIM_STROBE,
   output logic [2:0] O_DECIM_FACTOR,
   output logic O_REAL_DECIMATION,
   output logic O_NCO_PHASE_INVERT,
   // Mixer controls
   output logic [1:0] O_MIX_GAIN_A,
   output logic [1:0] O_MIX_GAIN_B,
   output logic O_NCO_RELOAD_A,
   output logic O_NCO_RELOAD_B,
   output logic O_QUARTER_MIX_A,
   output logic O_QUARTER_MIX_B
);
   initial begin
      if (SAMPLE_WIDTH < 2 || SAMPLE_WIDTH > 32) $error("SAMPLE_WIDTH out of range");
   end

   logic [7:0] path_routing_control;
   logic [7:0] decimation_control;
   logic [7:0] mixer_control;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic reload_a_prev;
   logic reload_b_prev;
   logic [SAMPLE_WIDTH-1:0] route_a;
   logic [SAMPLE_WIDTH-1:0] route_b;
   logic decim_tick;

   // Write channel capture in either order
   wire logic aw_fire = I_AWVALID && O_AWREADY;
   wire logic w_fire = I_WVALID && O_WREADY;
   wire logic have_aw = aw_held || aw_fire;
   wire logic have_w = w_held || w_fire;
   wire logic [7:0] cur_aw = aw_held ? aw_addr : I_AWADDR[9:2];
   wire logic [31:0] cur_w = w_held ? w_data : I_WDATA;
   wire logic [3:0] cur_strb = w_held ? w_strb : I_WSTRB;
   wire logic do_write = have_aw && have_w && !O_BVALID;
   wire logic aw_upper_ok = (aw_held || (I_AWADDR[31:10] == 22'h000000 && I_AWADDR[1:0] == 2'b00));
   wire logic wr_path = do_write && cur_aw == ddc_cfg_pkg::PATH_ROUTING_CONTROL_ADDR && aw_upper_ok;
   wire logic wr_decim = do_write && cur_aw == ddc_cfg_pkg::DECIMATION_CONTROL_ADDR && aw_upper_ok;
   wire logic wr_mixer = do_write && cur_aw == ddc_cfg_pkg::MIXER_CONTROL_ADDR && aw_upper_ok;
   wire logic wr_hit = wr_path || wr_decim || wr_mixer;
   wire logic [7:0] wbyte = cur_w[7:0];
   wire logic lane0 = cur_strb[0];

   // Read decode
   wire logic ar_fire = I_ARVALID && O_ARREADY;
   wire logic [7:0] ar_low = I_ARADDR[9:2];
   wire logic ar_upper_ok = (I_ARADDR[31:10] == 22'h000000 && I_ARADDR[1:0] == 2'b00);
   wire logic rd_path = ar_upper_ok && ar_low == ddc_cfg_pkg::PATH_ROUTING_CONTROL_ADDR;
   wire logic rd_decim = ar_upper_ok && ar_low == ddc_cfg_pkg::DECIMATION_CONTROL_ADDR;
   wire logic rd_mixer = ar_upper_ok && ar_low == ddc_cfg_pkg::MIXER_CONTROL_ADDR;
   wire logic rd_hit = rd_path || rd_decim || rd_mixer;
   wire logic [7:0] rd_byte = rd_path ? path_routing_control :
      rd_decim ? decimation_control :
      rd_mixer ? mixer_control : 8'h00;

   // Register next values; reserved positions are dropped
   wire logic [7:0] next_path = (wr_path && lane0) ? (wbyte & ddc_cfg_pkg::PATH_MASK) : path_routing_control;
   wire logic [7:0] next_decim = (wr_decim && lane0) ? (wbyte & ddc_cfg_pkg::DECIM_MASK) : decimation_control;
   wire logic [7:0] next_mixer = (wr_mixer && lane0) ? (wbyte & ddc_cfg_pkg::MIXER_MASK) : mixer_control;

   // Field decode
   wire logic avg_en = path_routing_control[ddc_cfg_pkg::AVG_BIT];
   wire logic [1:0] in_sel = path_routing_control[ddc_cfg_pkg::SEL_LSB +: 2];
   wire logic include_path = path_routing_control[ddc_cfg_pkg::INCLUDE_BIT];
   wire logic dec_en = path_routing_control[ddc_cfg_pkg::DEC_EN_BIT];
   wire logic route_en = decimation_control[ddc_cfg_pkg::ROUTE_EN_BIT];
   wire logic [2:0] factor = decimation_control[ddc_cfg_pkg::FACTOR_LSB +: 3];
   wire logic real_sel = decimation_control[ddc_cfg_pkg::REAL_BIT];
   wire logic phase_inv = decimation_control[ddc_cfg_pkg::PHASE_INV_BIT];
   wire logic [1:0] gain_a = mixer_control[ddc_cfg_pkg::GAIN_A_LSB +: 2];
   wire logic [1:0] gain_b = mixer_control[ddc_cfg_pkg::GAIN_B_LSB +: 2];
   wire logic reload_a = mixer_control[ddc_cfg_pkg::RELOAD_A_BIT];
   wire logic reload_b = mixer_control[ddc_cfg_pkg::RELOAD_B_BIT];
   wire logic qmix_a = mixer_control[ddc_cfg_pkg::QMIX_A_BIT];
   wire logic qmix_b = mixer_control[ddc_cfg_pkg::QMIX_B_BIT];

   // Digital path selection; decimation only counts with the path included
   wire logic decim_active = include_path && dec_en;
   wire logic [2:0] factor_eff = (factor <= ddc_cfg_pkg::FACTOR_MAX) ? factor : 3'h0;
   wire logic [SAMPLE_WIDTH-1:0] next_ddc_a = include_path ? route_a : I_SAMPLE_A;
   wire logic [SAMPLE_WIDTH-1:0] next_ddc_b = include_path ? route_b : I_SAMPLE_B;
   // Unused gain code is treated as no gain
   wire logic [1:0] gain_a_eff = (gain_a == ddc_cfg_pkg::GAIN_UNUSED) ? 2'b00 : gain_a;
   wire logic [1:0] gain_b_eff = (gain_b == ddc_cfg_pkg::GAIN_UNUSED) ? 2'b00 : gain_b;
   // Any edge of the reload bit is one reload pulse
   wire logic next_reload_a = reload_a ^ reload_a_prev;
   wire logic next_reload_b = reload_b ^ reload_b_prev;
   // Quarter-rate mixing is a complex operation, idle in real mode
   wire logic next_qmix_a = qmix_a && !real_sel;
   wire logic next_qmix_b = qmix_b && !real_sel;

   ddc_sample_router #(
      .WIDTH(SAMPLE_WIDTH)
   ) u_router (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_sample_a(I_SAMPLE_A),
      .i_sample_b(I_SAMPLE_B),
      .i_route_enable(route_en),
      .i_select(in_sel),
      .i_average_enable(avg_en),
      .o_ddc_a(route_a),
      .o_ddc_b(route_b)
   );

   ddc_decimator u_decim (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_enable(decim_active),
      .i_factor(factor_eff),
      .o_strobe(decim_tick)
   );

   // AXI4-Lite handshakes
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         O_AWREADY <= 1'b0;
         O_WREADY <= 1'b0;
         O_BVALID <= 1'b0;
         O_BRESP <= ddc_cfg_pkg::RESP_OKAY;
      end else begin
         O_AWREADY <= !have_aw && !O_BVALID;
         O_WREADY <= !have_w && !O_BVALID;
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            O_BVALID <= 1'b1;
            O_BRESP <= wr_hit ? ddc_cfg_pkg::RESP_OKAY : ddc_cfg_pkg::RESP_SLVERR;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
         end else begin
            if (aw_fire) begin
               aw_held <= 1'b1;
               // Misaligned or out-of-range addresses become an unmapped index
               aw_addr <= (I_AWADDR[31:10] == 22'h000000 && I_AWADDR[1:0] == 2'b00) ? I_AWADDR[9:2] : 8'hff;
            end
            if (w_fire) begin
               w_held <= 1'b1;
               w_data <= I_WDATA;
               w_strb <= I_WSTRB;
            end
            if (O_BVALID && I_BREADY) begin
               O_BVALID <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_ARREADY <= 1'b0;
         O_RVALID <= 1'b0;
         O_RDATA <= 32'h00000000;
         O_RRESP <= ddc_cfg_pkg::RESP_OKAY;
      end else begin
         O_ARREADY <= !O_RVALID && !ar_fire;
         if (ar_fire) begin
            O_RVALID <= 1'b1;
            O_RDATA <= {24'h000000, rd_byte};
            O_RRESP <= rd_hit ? ddc_cfg_pkg::RESP_OKAY : ddc_cfg_pkg::RESP_SLVERR;
         end else if (O_RVALID && I_RREADY) begin
            O_RVALID <= 1'b0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         path_routing_control <= ddc_cfg_pkg::REG_RESET;
         decimation_control <= ddc_cfg_pkg::REG_RESET;
         mixer_control <= ddc_cfg_pkg::REG_RESET;
      end else begin
         path_routing_control <= next_path;
         decimation_control <= next_decim;
         mixer_control <= next_mixer;
      end
   end

   // Registered outputs
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         reload_a_prev <= 1'b0;
         reload_b_prev <= 1'b0;
         O_DDC_A <= '0;
         O_DDC_B <= '0;
         O_DIGITAL_INCLUDE <= 1'b0;
         O_DECIM_STROBE <= 1'b0;
         O_DECIM_FACTOR <= 3'h0;
         O_REAL_DECIMATION <= 1'b0;
         O_NCO_PHASE_INVERT <= 1'b0;
         O_MIX_GAIN_A <= 2'b00;
         O_MIX_GAIN_B <= 2'b00;
         O_NCO_RELOAD_A <= 1'b0;
         O_NCO_RELOAD_B <= 1'b0;
         O_QUARTER_MIX_A <= 1'b0;
         O_QUARTER_MIX_B <= 1'b0;
      end else begin
         reload_a_prev <= reload_a;
         reload_b_prev <= reload_b;
         O_DDC_A <= next_ddc_a;
         O_DDC_B <= next_ddc_b;
         O_DIGITAL_INCLUDE <= include_path;
         O_DECIM_STROBE <= decim_active ? decim_tick : 1'b1;
         O_DECIM_FACTOR <= decim_active ? factor_eff : 3'h0;
         O_REAL_DECIMATION <= real_sel;
         O_NCO_PHASE_INVERT <= phase_inv;
         O_MIX_GAIN_A <= gain_a_eff;
         O_MIX_GAIN_B <= gain_b_eff;
         O_NCO_RELOAD_A <= next_reload_a;
         O_NCO_RELOAD_B <= next_reload_b;
         O_QUARTER_MIX_A <= next_qmix_a;
         O_QUARTER_MIX_B <= next_qmix_b;
      end
   end

   a_reserved_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (path_routing_control & ~ddc_cfg_pkg::PATH_MASK) == 8'h00 && (decimation_control & ~ddc_cfg_pkg::DECIM_MASK) == 8'h00)
      else $error("reserved bit stored");
   a_bypass_path: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      !include_path |=> O_DDC_A == $past(I_SAMPLE_A) && O_DDC_B == $past(I_SAMPLE_B))
      else $error("bypass path not direct");
   a_straight_route: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (include_path && route_en && in_sel == 2'b00) ##1 (include_path && $stable(decimation_control) && $stable(path_routing_control))
      |=> O_DDC_A == $past(I_SAMPLE_A, 2) && O_DDC_B == $past(I_SAMPLE_B, 2))
      else $error("straight route wrong");
   a_both_from_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (include_path && route_en && in_sel == 2'b01) ##1 (include_path && $stable(decimation_control) && $stable(path_routing_control))
      |=> O_DDC_A == $past(I_SAMPLE_A, 2) && O_DDC_B == $past(I_SAMPLE_A, 2))
      else $error("select 01 wrong");
   a_decim_off: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      !decim_active |=> O_DECIM_STROBE && O_DECIM_FACTOR == 3'h0)
      else $error("decimator not off");
   a_by_two_rate: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (decim_active && factor == 3'h1) ##1 (decim_active && factor == 3'h1 && O_DECIM_STROBE) |=> !O_DECIM_STROBE)
      else $error("decimate by 2 strobe wrong");
   a_real_mode: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      real_sel |=> O_REAL_DECIMATION && !O_QUARTER_MIX_A && !O_QUARTER_MIX_B)
      else $error("real mode mixing");
   a_phase_invert: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      1'b1 |=> O_NCO_PHASE_INVERT == $past(phase_inv))
      else $error("phase invert not followed");
   a_gain_code: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      O_MIX_GAIN_A != 2'b11 && O_MIX_GAIN_B != 2'b11)
      else $error("unused gain code out");
   a_reload_toggle: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $changed(reload_a) |=> O_NCO_RELOAD_A)
      else $error("reload pulse wrong");
   a_reload_steady: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      !$changed(reload_a) |=> !O_NCO_RELOAD_A)
      else $error("reload pulse without toggle");
   a_quarter_mix: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (qmix_b && !real_sel) |=> O_QUARTER_MIX_B)
      else $error("quarter mix not enabled");

   c_write_path: cover property (@(posedge I_REF_CLK) wr_path);
   c_average_route: cover property (@(posedge I_REF_CLK) avg_en && route_en && in_sel == 2'b11 && include_path);
   c_decim_32: cover property (@(posedge I_REF_CLK) decim_active && factor == 3'h5 && O_DECIM_STROBE);
   c_read_back: cover property (@(posedge I_REF_CLK) O_RVALID && I_RREADY && O_RDATA != 32'h0);
endmodule : ddc_path_config

// ==== ddc_path_config_tb.sv ====
`timescale 1ns/1ps
module ddc_path_config_tb;
   logic clk, rst_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [31:0] awa, wd, ara, rd, q;
   logic [3:0] ws;
   logic [1:0] bresp, rresp, ga, gb, r;
   logic [15:0] sa, sb, da, db;
   logic inc, stb, rdec, pinv, rla, rlb, qa, qb;
   logic [2:0] fac, fc, p;
   logic [7:0] v, old;
   logic [15:0] hist_a [3];
   logic [15:0] hist_b [3];
   int error_cnt = 0;
   int checks_done = 0;
   int rl_a = 0;
   int rl_b = 0;
   int n, ca, cb;

   ddc_path_config #(.SAMPLE_WIDTH(16)) dut (
      .I_REF_CLK(clk), .I_RST_N(rst_n),
      .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
      .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(ws),
      .O_BVALID(bv), .I_BREADY(br), .O_BRESP(bresp),
      .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
      .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rd), .O_RRESP(rresp),
      .I_SAMPLE_A(sa), .I_SAMPLE_B(sb), .O_DDC_A(da), .O_DDC_B(db),
      .O_DIGITAL_INCLUDE(inc), .O_DECIM_STROBE(stb), .O_DECIM_FACTOR(fac),
      .O_REAL_DECIMATION(rdec), .O_NCO_PHASE_INVERT(pinv),
      .O_MIX_GAIN_A(ga), .O_MIX_GAIN_B(gb), .O_NCO_RELOAD_A(rla), .O_NCO_RELOAD_B(rlb),
      .O_QUARTER_MIX_A(qa), .O_QUARTER_MIX_B(qb)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Reload pulses are counted as they pass
   always @(posedge clk) begin
      if (rla === 1'b1) rl_a++;
      if (rlb === 1'b1) rl_b++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   task automatic guard(input int cnt);
      if (cnt > 50) begin
         error_cnt++;
         $display("unexpected at %0t: bus wait ran out", $time);
         test_done();
      end
   endtask : guard

   task automatic bus_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
      int cnt;
      bit a_ok, w_ok;
      cnt = 0;
      a_ok = 0;
      w_ok = 0;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      br <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(posedge clk);
         if (!a_ok && awr === 1'b1) begin
            a_ok = 1;
            awv <= 1'b0;
         end
         if (!w_ok && wr === 1'b1) begin
            w_ok = 1;
            wv <= 1'b0;
         end
         cnt++;
         guard(cnt);
      end
      while (bv !== 1'b1) begin
         @(posedge clk);
         cnt++;
         guard(cnt);
      end
      resp = bresp;
      br <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
      int cnt;
      cnt = 0;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         cnt++;
         guard(cnt);
      end while (arr !== 1'b1);
      arv <= 1'b0;
      do begin
         @(posedge clk);
         cnt++;
         guard(cnt);
      end while (rv !== 1'b1);
      d = rd;
      resp = rresp;
      rr <= 1'b0;
   endtask : bus_rd

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = (a == 8'h24) ? ddc_cfg_pkg::PATH_MASK : (a == 8'h25) ? ddc_cfg_pkg::DECIM_MASK : ddc_cfg_pkg::MIXER_MASK;
      bus_wr({22'h0, a, 2'b00}, {24'h0, d}, r);
      chk(32'(r), 32'(ddc_cfg_pkg::RESP_OKAY), "write resp");
      bus_rd({22'h0, a, 2'b00}, q, r);
      chk(32'(r), 32'(ddc_cfg_pkg::RESP_OKAY), "read resp");
      chk(q, {24'h0, d & m}, "readback");
   endtask : reg_wr

   // Random samples; hist index equals the expected latency in cycles
   task automatic stream(input int lat, input logic ren, input logic [1:0] sel, input logic avg);
      logic [15:0] a, b, ea, eb;
      logic signed [16:0] s;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         hist_a[2] = hist_a[1];
         hist_a[1] = hist_a[0];
         hist_a[0] = 16'($urandom);
         hist_b[2] = hist_b[1];
         hist_b[1] = hist_b[0];
         hist_b[0] = 16'($urandom);
         sa <= hist_a[0];
         sb <= hist_b[0];
         @(negedge clk);
         if (i >= 3) begin
            a = hist_a[lat];
            b = hist_b[lat];
            s = $signed({a[15], a}) + $signed({b[15], b});
            ea = (ren && sel == 2'b10) ? b : a;
            eb = (ren && sel != 2'b00) ? ((sel == 2'b10) ? b : a) : b;
            if (ren && sel == 2'b11 && avg) begin
               ea = s[16:1];
               eb = s[16:1];
            end
            chk(32'(da), 32'(ea), "ddc a");
            chk(32'(db), 32'(eb), "ddc b");
         end
      end
   endtask : stream

   initial begin
      {awv, wv, br, arv, rr} = '0;
      {awa, wd, ara} = '0;
      ws = 4'hf;
      sa = 16'h0000;
      sb = 16'h0000;
      rst_n = 1'b0;
      void'($urandom(79559));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 8'h24; a <= 8'h26; a++) begin
         bus_rd(32'(a * 4), q, r);
         chk(q, 32'h0, "reset value");
      end
      $display("test reset values done");
      reg_wr(8'h24, 8'hff);
      reg_wr(8'h25, 8'hff);
      reg_wr(8'h26, 8'hff);
      bus_wr(32'h28, 32'hff, r);
      chk(32'(r), 32'(ddc_cfg_pkg::RESP_SLVERR), "unmapped write");
      bus_rd(32'h28, q, r);
      chk(q, 32'h0, "unmapped data");
      chk(32'(r), 32'(ddc_cfg_pkg::RESP_SLVERR), "unmapped read");
      $display("test register access done");
      reg_wr(8'h24, 8'h00);
      reg_wr(8'h25, 8'h00);
      reg_wr(8'h26, 8'h00);
      stream(1, 1'b0, 2'b00, 1'b0);
      for (int m = 0; m < 16; m++) begin
         reg_wr(8'h24, {2'b00, m[0], m[2:1], 3'b110});
         reg_wr(8'h25, {m[3], 7'h0});
         stream(2, m[3], m[2:1], m[0]);
      end
      $display("test routing done");
      for (int f = 0; f < 10; f++) begin
         fc = (f < 8) ? f[2:0] : 3'h3;
         reg_wr(8'h24, (f < 8) ? 8'h06 : ((f == 8) ? 8'h04 : 8'h02));
         reg_wr(8'h25, {1'b0, fc, f[0], 2'b00, f[1]});
         repeat (40) @(posedge clk);
         n = 0;
         repeat (64) begin
            @(posedge clk);
            if (stb === 1'b1) n++;
         end
         p = (f < 8 && fc <= 3'h5) ? fc : 3'h0;
         chk(32'(n), 32'(64 >> p), "strobe count");
         chk(32'(fac), 32'(p), "factor");
         chk(32'(inc), 32'(f != 9), "include");
         chk(32'(rdec), 32'(f[0]), "real mode");
         chk(32'(pinv), 32'(f[1]), "phase invert");
      end
      $display("test decimation done");
      old = 8'h00;
      for (int k = 0; k < 12; k++) begin
         v = 8'($urandom);
         reg_wr(8'h25, {4'h0, k[0], 3'h0});
         ca = rl_a;
         cb = rl_b;
         reg_wr(8'h26, v);
         repeat (3) @(posedge clk);
         chk(32'(rl_a - ca), 32'(v[5] != old[5]), "reload a");
         chk(32'(rl_b - cb), 32'(v[1] != old[1]), "reload b");
         old = v;
         chk(32'(ga), 32'((v[7:6] == 2'b11) ? 2'b00 : v[7:6]), "gain a");
         chk(32'(gb), 32'((v[3:2] == 2'b11) ? 2'b00 : v[3:2]), "gain b");
         chk(32'(qa), 32'(v[4] & ~k[0]), "quarter a");
         chk(32'(qb), 32'(v[0] & ~k[0]), "quarter b");
      end
      $display("test mixer done");
      test_done();
   end
endmodule : ddc_path_config_tb

// ==== ddc_sample_router.sv ====
`timescale 1ns/1ps
module ddc_sample_router #(
   parameter int WIDTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_sample_a,
   input wire logic [WIDTH-1:0] i_sample_b,
   input wire logic i_route_enable,
   input wire logic [1:0] i_select,
   input wire logic i_average_enable,
   output logic [WIDTH-1:0] o_ddc_a,
   output logic [WIDTH-1:0] o_ddc_b
);
   wire logic [WIDTH:0] sum_ab = {i_sample_a[WIDTH-1], i_sample_a} + {i_sample_b[WIDTH-1], i_sample_b};
   wire logic [WIDTH-1:0] average = sum_ab[WIDTH:1];
   wire logic [WIDTH-1:0] avg_src = i_average_enable ? average : i_sample_a;
   wire logic [1:0] eff_sel = i_route_enable ? i_select : ddc_cfg_pkg::SEL_STRAIGHT;
   wire logic [WIDTH-1:0] next_a = (eff_sel == ddc_cfg_pkg::SEL_BOTH_B) ? i_sample_b :
      (eff_sel == ddc_cfg_pkg::SEL_AVERAGE) ? avg_src : i_sample_a;
   wire logic [WIDTH-1:0] next_b = (eff_sel == ddc_cfg_pkg::SEL_BOTH_A) ? i_sample_a :
      (eff_sel == ddc_cfg_pkg::SEL_AVERAGE) ? avg_src : i_sample_b;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ddc_a <= '0;
         o_ddc_b <= '0;
      end else begin
         o_ddc_a <= next_a;
         o_ddc_b <= next_b;
      end
   end

   a_route_average: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_route_enable && i_select == 2'b11 && i_average_enable) |=> (o_ddc_a == $past(average) && o_ddc_b == o_ddc_a))
      else $error("average not routed to both");
   a_route_disabled: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_route_enable |=> (o_ddc_a == $past(i_sample_a) && o_ddc_b == $past(i_sample_b)))
      else $error("disabled router not straight");
   a_route_both_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_route_enable && i_select == 2'b10) |=> (o_ddc_a == $past(i_sample_b) && o_ddc_b == $past(i_sample_b)))
      else $error("select 10 wrong");
endmodule : ddc_sample_router
